// [src/nvm_pkg.sv]
/*
 * Constants, types and helpers for the nonvolatile memory control block.
 * Assumes a single 100 MHz core clock and an 8-bit register port.
 */
// Notes on behaviour
// - Control register sits at data address FA6h
// - Write start runs self-timed cycle, cleared when done
// - Software can set, never clear, write start
// - Write enable zero blocks any write or erase
// - Reset during programming sets error; completion clears
// - Read start does one-cycle read, then self-clears
// - Software can set, never clear, read start
// - Read start refused while program memory selected
// - Eight-bit table latch, software readable and writable
// - Latch takes table-read bytes, feeds table writes
// - Memory select picks program or data memory
// - Config select overrides memory select for writes and erases; reads ignore it
// - Erase enable turns next program memory write into row erase
package nvm_pkg;

    // Register map
    localparam logic [11:0] NVM_CONTROL_ADDR = 12'hFA6;
    localparam logic [11:0] UNLOCK_PORT_ADDR = 12'hFA7;
    localparam logic [11:0] TABLE_LATCH_ADDR = 12'hFF5;
    localparam logic [11:0] IRQ_STATUS_ADDR  = 12'hFA0;
    localparam logic [11:0] IRQ_MASK_ADDR    = 12'hFA1;

    // Control register fields
    localparam int READ_START_BIT    = 0;
    localparam int WRITE_START_BIT   = 1;
    localparam int WRITE_ENABLE_BIT  = 2;
    localparam int WRITE_ERROR_BIT   = 3;
    localparam int ERASE_ENABLE_BIT  = 4;
    localparam int CONFIG_SELECT_BIT = 6;
    localparam int MEMORY_SELECT_BIT = 7;

    // Reset values
    localparam logic [7:0] CONTROL_RESET     = 8'h00;
    localparam logic [7:0] TABLE_LATCH_RESET = 8'h00;
    localparam logic [1:0] IRQ_MASK_RESET    = 2'h0;

    // Unlock keys
    localparam logic [7:0] UNLOCK_KEY_FIRST  = 8'h55;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;

    // Timing
    localparam int CLK_FREQ_MHZ  = 100;
    localparam int ERASE_TIME_US = 2000;
    localparam int WRITE_TIME_US = 2000;
    localparam int ERASE_CYCLES  = ERASE_TIME_US * CLK_FREQ_MHZ;
    localparam int WRITE_CYCLES  = WRITE_TIME_US * CLK_FREQ_MHZ;
    localparam int TIMER_WIDTH   = 18;

    // Interrupt events
    localparam int EV_DONE   = 0;
    localparam int EV_ERROR  = 1;
    localparam int N_EVENTS  = 2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_DONE = 2'b11
    } op_state_t;

    typedef enum logic [1:0] {
        TGT_EEPROM  = 2'b00,
        TGT_PROGRAM = 2'b01,
        TGT_CONFIG  = 2'b10
    } target_t;

    // Config select wins over memory select
    function automatic target_t decode_target(input logic cfg, input logic mem);
        if (cfg) begin
            return TGT_CONFIG;
        end
        return mem ? TGT_PROGRAM : TGT_EEPROM;
    endfunction : decode_target

endpackage : nvm_pkg

// [src/op_timer.sv]
/*
 * Down-counter that times one self-timed programming cycle.
 * Assumes start and abort come from logic on the same clock.
 */
`timescale 1ns/1ps
module op_timer
    import nvm_pkg::*;
#(
    parameter int WIDTH = TIMER_WIDTH
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // Control
    input  wire logic             start,
    input  wire logic             abort,
    input  wire logic [WIDTH-1:0] load,
    // Status
    output logic                  busy,
    output logic                  expired
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    // Abort wins so a cut-short cycle never reports expiry
    always_comb begin
        next_count = count;
        if (abort) begin
            next_count = '0;
        end else if (start) begin
            next_count = load;
        end else if (count != '0) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign busy    = (count != '0);
    assign expired = (count == {{(WIDTH-1){1'b0}}, 1'b1}) && !abort;

endmodule : op_timer

// [src/event_flags.sv]
/*
 * Sticky event status with write-one-to-clear, a mask and a level
 * interrupt. Assumes register strobes from the same clock.
 */
`timescale 1ns/1ps
module event_flags
    import nvm_pkg::*;
#(
    parameter int N = N_EVENTS
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // Events
    input  wire logic [N-1:0] events,
    // Software access
    input  wire logic         status_write,
    input  wire logic         mask_write,
    input  wire logic [N-1:0] wdata,
    // State
    output logic [N-1:0]      status,
    output logic [N-1:0]      mask,
    output logic              irq
);
    logic [N-1:0] next_status;
    logic [N-1:0] next_mask;

    // Set wins over a clear in the same cycle, so no event is lost
    always_comb begin
        next_status = status;
        next_mask   = mask;
        if (status_write) begin
            next_status = status & ~wdata;
        end
        next_status = next_status | events;
        if (mask_write) begin
            next_mask = wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status <= '0;
            mask   <= IRQ_MASK_RESET;
        end else begin
            status <= next_status;
            mask   <= next_mask;
        end
    end

    assign irq = |(status & mask);

endmodule : event_flags

// [src/nvm_write_erase_control.sv]
/*
 * Control and status for self-timed writes and row erases of program
 * flash, writes and reads of data EEPROM, plus the table latch.
 * Assumes the core drives the register port on the core clock and
 * raises warm_reset for any non-power-on reset; the memory array
 * acts on the start strobes and target code given here.
 */
`timescale 1ns/1ps
module nvm_write_erase_control
    import nvm_pkg::*;
#(
    parameter int ERASE_COUNT = ERASE_CYCLES,
    parameter int WRITE_COUNT = WRITE_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Register port
    input  wire logic [11:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [7:0]       reg_rdata,
    // Warm reset request from the core
    input  wire logic        warm_reset,
    // Table transfer
    input  wire logic        table_read_load,
    input  wire logic [7:0]  table_read_byte,
    output logic [7:0]       table_latch_out,
    // Memory array side
    output logic [1:0]       op_target,
    output logic             write_start,
    output logic             erase_start,
    output logic             op_abort,
    output logic             eeprom_read_start,
    output logic             nvm_busy,
    // Interrupt
    output logic             irq
);

    // Control register bits
    logic memory_select;
    logic config_select;
    logic erase_enable;
    logic write_error_flag;
    logic write_enable_bit;
    logic write_start_bit;
    logic read_start_bit;
    logic next_memory_select;
    logic next_config_select;
    logic next_erase_enable;
    logic next_write_error_flag;
    logic next_write_enable_bit;
    logic next_write_start_bit;
    logic next_read_start_bit;

    // Other state
    logic [7:0] table_latch;
    logic [7:0] next_table_latch;
    logic [1:0] unlock_stage;
    logic [1:0] next_unlock_stage;
    logic [1:0] target;
    logic [1:0] next_target;
    logic       erase_op;
    logic       next_erase_op;
    logic [7:0] next_reg_rdata;
    op_state_t  state;
    op_state_t  next_state;

    // Decodes and handshakes
    logic       ctl_write;
    logic       unlock_write;
    logic       latch_write;
    logic       accept_write;
    logic       accept_read;
    logic       do_erase;
    logic       launch;
    logic       next_launch;
    logic       timer_expired;
    logic       abort_now;
    logic [7:0] control_view;
    logic [TIMER_WIDTH-1:0] timer_load;
    logic [N_EVENTS-1:0]    ev;
    logic [N_EVENTS-1:0]    irq_status;
    logic [N_EVENTS-1:0]    irq_mask;
    target_t    sel_target;

    // Address decode
    assign ctl_write    = reg_write && (reg_addr == NVM_CONTROL_ADDR);
    assign unlock_write = reg_write && (reg_addr == UNLOCK_PORT_ADDR);
    assign latch_write  = reg_write && (reg_addr == TABLE_LATCH_ADDR);

    // Target from the select bits as they stand before this write
    assign sel_target = decode_target(config_select, memory_select);

    // Start a timed cycle only when enabled, unlocked and idle
    assign accept_write = ctl_write && reg_wdata[WRITE_START_BIT]
                          && write_enable_bit
                          && (unlock_stage == 2'd2)
                          && (state == ST_IDLE)
                          && !warm_reset;

    // A read needs data memory selected and no cycle running
    assign accept_read = ctl_write && reg_wdata[READ_START_BIT]
                         && !memory_select
                         && (state == ST_IDLE)
                         && !accept_write
                         && !warm_reset;

    // Erase only applies to program memory rows
    assign do_erase = erase_enable && (sel_target == TGT_PROGRAM);
    // Erase and write may differ in length
    assign timer_load = do_erase ? ERASE_COUNT[TIMER_WIDTH-1:0]
                                 : WRITE_COUNT[TIMER_WIDTH-1:0];
    // A warm reset while running cuts the cycle short
    assign abort_now = warm_reset && (state == ST_RUN);

    op_timer #(
        .WIDTH   (TIMER_WIDTH)
    ) u_timer (
        .clk     (clk),
        .rstn    (rstn),
        .start   (accept_write),
        .abort   (abort_now),
        .load    (timer_load),
        .busy    (),
        .expired (timer_expired)
    );

    // Operation sequencer
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: next_state = accept_write ? ST_RUN : ST_IDLE;
            ST_RUN: begin
                if (abort_now) begin
                    next_state = ST_IDLE;
                end else if (timer_expired) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Control register next values
    always_comb begin
        next_memory_select    = memory_select;
        next_config_select    = config_select;
        next_erase_enable     = erase_enable;
        next_write_enable_bit = write_enable_bit;
        next_write_error_flag = write_error_flag;
        next_write_start_bit  = write_start_bit;
        next_read_start_bit   = 1'b0;
        // Selects frozen while a cycle runs so the target stays put
        if (ctl_write && (state == ST_IDLE)) begin
            next_memory_select    = reg_wdata[MEMORY_SELECT_BIT];
            next_config_select    = reg_wdata[CONFIG_SELECT_BIT];
            next_erase_enable     = reg_wdata[ERASE_ENABLE_BIT];
            next_write_enable_bit = reg_wdata[WRITE_ENABLE_BIT];
        end
        if (ctl_write) begin
            next_write_error_flag = reg_wdata[WRITE_ERROR_BIT];
        end
        // Start bits only set from software; a zero is ignored
        if (accept_write) begin
            next_write_start_bit = 1'b1;
        end
        if (accept_read) begin
            next_read_start_bit = 1'b1;
        end
        // Completion clears start and leaves no error
        if (state == ST_DONE) begin
            next_write_start_bit  = 1'b0;
            next_write_error_flag = 1'b0;
        end
        // Warm reset keeps the selects so software can retry
        if (warm_reset) begin
            next_erase_enable     = 1'b0;
            next_write_enable_bit = 1'b0;
            next_write_start_bit  = 1'b0;
            next_read_start_bit   = 1'b0;
        end
        // Hardware set wins over any software clear
        if (abort_now) begin
            next_write_error_flag = 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            memory_select    <= CONTROL_RESET[MEMORY_SELECT_BIT];
            config_select    <= CONTROL_RESET[CONFIG_SELECT_BIT];
            erase_enable     <= CONTROL_RESET[ERASE_ENABLE_BIT];
            write_error_flag <= CONTROL_RESET[WRITE_ERROR_BIT];
            write_enable_bit <= CONTROL_RESET[WRITE_ENABLE_BIT];
            write_start_bit  <= CONTROL_RESET[WRITE_START_BIT];
            read_start_bit   <= CONTROL_RESET[READ_START_BIT];
        end else begin
            memory_select    <= next_memory_select;
            config_select    <= next_config_select;
            erase_enable     <= next_erase_enable;
            write_error_flag <= next_write_error_flag;
            write_enable_bit <= next_write_enable_bit;
            write_start_bit  <= next_write_start_bit;
            read_start_bit   <= next_read_start_bit;
        end
    end

    // Unlock sequence: first key, then second key, then start
    always_comb begin
        next_unlock_stage = unlock_stage;
        if (warm_reset) begin
            next_unlock_stage = 2'd0;
        end else if (unlock_write) begin
            if (reg_wdata == UNLOCK_KEY_FIRST) begin
                next_unlock_stage = 2'd1;
            end else if ((unlock_stage == 2'd1) && (reg_wdata == UNLOCK_KEY_SECOND)) begin
                next_unlock_stage = 2'd2;
            end else begin
                next_unlock_stage = 2'd0;
            end
        end else if (reg_write) begin
            // Any other write spends or breaks the sequence
            next_unlock_stage = 2'd0;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            unlock_stage <= 2'd0;
        end else begin
            unlock_stage <= next_unlock_stage;
        end
    end

    // Target and kind captured at start; launch marks the first cycle
    always_comb begin
        next_target   = target;
        next_erase_op = erase_op;
        next_launch   = accept_write;
        if (accept_write) begin
            next_target   = sel_target;
            next_erase_op = do_erase;
        end else if (accept_read) begin
            next_target   = TGT_EEPROM;
            next_erase_op = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            target   <= TGT_EEPROM;
            erase_op <= 1'b0;
            launch   <= 1'b0;
        end else begin
            target   <= next_target;
            erase_op <= next_erase_op;
            launch   <= next_launch;
        end
    end

    // Table latch: a table read beats a software write
    always_comb begin
        next_table_latch = table_latch;
        if (table_read_load) begin
            next_table_latch = table_read_byte;
        end else if (latch_write) begin
            next_table_latch = reg_wdata;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            table_latch <= TABLE_LATCH_RESET;
        end else begin
            table_latch <= next_table_latch;
        end
    end

    // Register view; bit 5 is always zero
    assign control_view = {memory_select, config_select, 1'b0,
                           erase_enable, write_error_flag,
                           write_enable_bit, write_start_bit, read_start_bit};

    // Read data one cycle after the strobe, zero otherwise
    always_comb begin
        next_reg_rdata = 8'h00;
        if (reg_read) begin
            case (reg_addr)
                NVM_CONTROL_ADDR: next_reg_rdata = control_view;
                TABLE_LATCH_ADDR: next_reg_rdata = table_latch;
                IRQ_STATUS_ADDR:  next_reg_rdata = {6'h00, irq_status};
                IRQ_MASK_ADDR:    next_reg_rdata = {6'h00, irq_mask};
                default:          next_reg_rdata = 8'h00; // Unlock port too
            endcase
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    // Completion and abort raise sticky events
    assign ev[EV_DONE]  = (state == ST_DONE);
    assign ev[EV_ERROR] = abort_now;

    event_flags #(
        .N            (N_EVENTS)
    ) u_flags (
        .clk          (clk),
        .rstn         (rstn),
        .events       (ev),
        .status_write (reg_write && (reg_addr == IRQ_STATUS_ADDR)),
        .mask_write   (reg_write && (reg_addr == IRQ_MASK_ADDR)),
        .wdata        (reg_wdata[N_EVENTS-1:0]),
        .status       (irq_status),
        .mask         (irq_mask),
        .irq          (irq)
    );

    // Array side strobes
    assign op_target         = target;
    assign write_start       = launch && !erase_op;
    assign erase_start       = launch && erase_op;
    assign op_abort          = abort_now;
    assign eeprom_read_start = read_start_bit;
    assign nvm_busy          = write_start_bit;
    assign table_latch_out   = table_latch;

endmodule : nvm_write_erase_control

// [tb/nvm_control_props.sv]
/*
 * Concurrent checks on the ports of the memory control block.
 * Assumes one core clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
module nvm_control_props
    import nvm_pkg::*;
#(
    parameter int ERASE_COUNT = ERASE_CYCLES,
    parameter int WRITE_COUNT = WRITE_CYCLES
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [7:0]  reg_rdata,
    input wire logic        warm_reset,
    // Table transfer
    input wire logic        table_read_load,
    input wire logic [7:0]  table_read_byte,
    input wire logic [7:0]  table_latch_out,
    // Memory array side
    input wire logic [1:0]  op_target,
    input wire logic        write_start,
    input wire logic        erase_start,
    input wire logic        op_abort,
    input wire logic        eeprom_read_start,
    input wire logic        nvm_busy
);
    localparam int MIN_COUNT = (ERASE_COUNT < WRITE_COUNT) ? ERASE_COUNT : WRITE_COUNT;
    int busy_cnt;
    int next_busy_cnt;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // Busy length; an early fall means the timer is short
    always_comb begin
        next_busy_cnt = nvm_busy ? busy_cnt + 1 : 0;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= next_busy_cnt;
        end
    end

    rdata_quiet_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("stray read data");
    bit5_zero_a: assert property ($past(reg_read) && $past(reg_addr) == NVM_CONTROL_ADDR
        |-> reg_rdata[5] == 1'b0)
        else $error("bit 5 reads one");
    busy_cause_a: assert property ($rose(nvm_busy) |-> $past(reg_write) && !$past(warm_reset)
        && $past(reg_addr) == NVM_CONTROL_ADDR && $past(reg_wdata[WRITE_START_BIT]))
        else $error("busy without start");
    busy_time_a: assert property ($fell(nvm_busy) && !$past(warm_reset)
        |-> busy_cnt >= MIN_COUNT)
        else $error("cycle too short");
    read_cause_a: assert property (eeprom_read_start |-> $past(reg_write) && !$past(nvm_busy)
        && $past(reg_addr) == NVM_CONTROL_ADDR && $past(reg_wdata[READ_START_BIT]))
        else $error("read without start");
    read_single_a: assert property (eeprom_read_start |=> !eeprom_read_start)
        else $error("read pulse too long");
    abort_cause_a: assert property (op_abort |-> warm_reset && nvm_busy)
        else $error("stray abort");
    abort_clear_a: assert property (warm_reset && nvm_busy |-> op_abort ##1 !nvm_busy)
        else $error("cycle not cut");
    target_hold_a: assert property (nvm_busy && $past(nvm_busy) |-> $stable(op_target))
        else $error("target moved");
    latch_load_a: assert property (table_read_load
        |=> table_latch_out == $past(table_read_byte))
        else $error("latch missed byte");
    launch_pulse_a: assert property (write_start || erase_start
        |-> $rose(nvm_busy) && !(write_start && erase_start))
        else $error("launch without start");
endmodule : nvm_control_props

bind nvm_write_erase_control nvm_control_props #(
    .ERASE_COUNT(ERASE_COUNT),
    .WRITE_COUNT(WRITE_COUNT)
) props (.*);

// [tb/core_table_model.sv]
/*
 * Core side of table moves: fills and drains the latch.
 * Assumes the core clock.
 */
`timescale 1ns/1ps
module core_table_model (
    // Clock
    input  wire logic       clk,
    // Table read path
    output logic            table_read_load,
    output logic [7:0]      table_read_byte,
    // Latch contents
    input  wire logic [7:0] table_latch_out
);
    // Idle bus shows a junk byte, not a stale one
    initial begin
        table_read_load = 1'b0;
        table_read_byte = 8'hA5;
    end
    // One table read, byte beside the strobe
    task automatic fetch(input logic [7:0] b);
        @(posedge clk);
        table_read_load <= 1'b1;
        table_read_byte <= b;
        @(posedge clk);
        table_read_load <= 1'b0;
        table_read_byte <= ~b;
    endtask : fetch
    // Table write takes the latch byte
    task automatic store(output logic [7:0] b);
        b = table_latch_out;
    endtask : store
endmodule : core_table_model

// [tb/testbench.sv]
/*
 * Self-checking bench for the memory control block.
 * Assumes short timed counts and a core model on the table path.
 */
`timescale 1ns/1ps
module testbench
    import nvm_pkg::*;
;
    localparam int N_OP = 20;
    logic        clk, rstn, reg_write, reg_read, warm_reset, table_read_load;
    logic        write_start, erase_start, op_abort, eeprom_read_start, nvm_busy, irq;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, table_read_byte, table_latch_out, d, v, m_ctrl;
    logic [1:0]  op_target;
    int          num_errors, total_checks, cycles, seed;
    logic [11:0] blank[5] = '{NVM_CONTROL_ADDR, TABLE_LATCH_ADDR, UNLOCK_PORT_ADDR,
                              IRQ_MASK_ADDR, 12'hFA5};

    nvm_write_erase_control #(.ERASE_COUNT(N_OP), .WRITE_COUNT(N_OP)) DUT (
        .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .warm_reset(warm_reset), .table_read_load(table_read_load),
        .table_read_byte(table_read_byte), .table_latch_out(table_latch_out),
        .op_target(op_target), .write_start(write_start), .erase_start(erase_start),
        .op_abort(op_abort), .eeprom_read_start(eeprom_read_start),
        .nvm_busy(nvm_busy), .irq(irq));
    core_table_model core (.clk(clk), .table_read_load(table_read_load),
        .table_read_byte(table_read_byte), .table_latch_out(table_latch_out));

    // Core clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Hang guard, far above a full run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            $display("Error at %0t: run hung", $time);
            tally_and_finish();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk1(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask : chk1
    // Gap edge after each strobe
    task automatic wr(input logic [11:0] a, input logic [7:0] w);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= w;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [7:0] r);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        r = reg_rdata;
    endtask : rd
    task automatic unlock();
        wr(UNLOCK_PORT_ADDR, UNLOCK_KEY_FIRST);
        wr(UNLOCK_PORT_ADDR, UNLOCK_KEY_SECOND);
    endtask : unlock
    task automatic irq_is(input logic e);
        @(posedge clk);
        #1;
        chk1(irq, e);
    endtask : irq_is
    // Unlocked start, zero-write, completion
    task automatic run_op(input logic [7:0] setup, input logic [1:0] tgt);
        int n;
        wr(NVM_CONTROL_ADDR, setup);
        m_ctrl = setup & 8'hD4;
        unlock();
        wr(NVM_CONTROL_ADDR, setup | 8'h02);
        chk1(nvm_busy, 1'b1);
        chk({6'h00, op_target}, {6'h00, tgt});
        chk({6'h00, write_start, erase_start}, tgt == 2'h1 && setup[4] ? 8'h01 : 8'h02);
        rd(NVM_CONTROL_ADDR, d);
        chk(d & 8'hF7, m_ctrl | 8'h02);
        wr(NVM_CONTROL_ADDR, m_ctrl | 8'h08);
        chk1(nvm_busy, 1'b1);
        n = 0;
        while (nvm_busy === 1'b1 && n < 3 * N_OP) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk1(nvm_busy, 1'b0);
        rd(NVM_CONTROL_ADDR, d);
        chk(d, m_ctrl);
        $display("Test op to target %0d done", tgt);
    endtask : run_op

    task automatic tally_and_finish();
        $display("Checks %0d, errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial begin
        seed = 43;
        {rstn, reg_write, reg_read, warm_reset} = 4'h0;
        reg_addr = 12'h000;
        reg_wdata = 8'h00;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        foreach (blank[i]) begin
            rd(blank[i], d);
            chk(d, 8'h00);
        end
        $display("Test reset values done");
        repeat (3) begin
            v = 8'($random(seed));
            wr(TABLE_LATCH_ADDR, v);
            rd(TABLE_LATCH_ADDR, d);
            chk(d, v);
            chk(table_latch_out, v);
            core.fetch(~v);
            rd(TABLE_LATCH_ADDR, d);
            chk(d, ~v);
            core.store(d);
            chk(d, ~v);
        end
        $display("Test table latch done");
        wr(NVM_CONTROL_ADDR, 8'h04);
        wr(NVM_CONTROL_ADDR, 8'h06);
        chk1(nvm_busy, 1'b0);
        wr(NVM_CONTROL_ADDR, 8'h00);
        unlock();
        wr(NVM_CONTROL_ADDR, 8'h02);
        chk1(nvm_busy, 1'b0);
        rd(NVM_CONTROL_ADDR, d);
        chk(d, 8'h00);
        $display("Test refused starts done");
        run_op(8'h94, 2'h1);
        run_op(8'hC4, 2'h2);
        run_op(8'h04, 2'h0);
        wr(NVM_CONTROL_ADDR, 8'h01);
        chk1(eeprom_read_start, 1'b1);
        @(posedge clk);
        #1;
        chk1(eeprom_read_start, 1'b0);
        rd(NVM_CONTROL_ADDR, d);
        chk(d, 8'h00);
        wr(NVM_CONTROL_ADDR, 8'h80);
        wr(NVM_CONTROL_ADDR, 8'h81);
        chk1(eeprom_read_start, 1'b0);
        rd(NVM_CONTROL_ADDR, d);
        chk(d, 8'h80);
        wr(NVM_CONTROL_ADDR, 8'h00);
        chk1(eeprom_read_start, 1'b0);
        $display("Test data read done");
        wr(IRQ_STATUS_ADDR, 8'h03);
        wr(NVM_CONTROL_ADDR, 8'h04);
        unlock();
        wr(NVM_CONTROL_ADDR, 8'h06);
        repeat (3) @(posedge clk);
        warm_reset <= 1'b1;
        #1;
        chk1(op_abort, 1'b1);
        @(posedge clk);
        warm_reset <= 1'b0;
        #1;
        chk1(nvm_busy, 1'b0);
        rd(NVM_CONTROL_ADDR, d);
        chk(d, 8'h08);
        rd(IRQ_STATUS_ADDR, d);
        chk(d, 8'h02);
        irq_is(1'b0);
        wr(IRQ_MASK_ADDR, 8'h02);
        irq_is(1'b1);
        wr(IRQ_MASK_ADDR, 8'h00);
        irq_is(1'b0);
        wr(IRQ_MASK_ADDR, 8'h02);
        wr(IRQ_STATUS_ADDR, 8'h02);
        irq_is(1'b0);
        $display("Test abort and interrupt done");
        run_op(8'h04, 2'h0);
        rd(IRQ_STATUS_ADDR, d);
        chk(d, 8'h01);
        tally_and_finish();
    end
endmodule : testbench
